// ---- logic/pfd_pkg.sv ----
package pfd_pkg;
  // APB register map (byte addresses)
  localparam logic [7:0] PFD_ROM_LIMIT_OFF = 8'h00;
  localparam logic [7:0] PFD_STATUS_OFF = 8'h04;
  localparam logic [7:0] PFD_FETCH_CNT_OFF = 8'h08;
  // Size-select field
  localparam int PFD_SEL_LSB = 0;
  localparam int PFD_SEL_W = 3;
  localparam logic [2:0] PFD_SEL_NONE = 3'h0;
  localparam logic [2:0] PFD_SEL_1K = 3'h1;
  localparam logic [2:0] PFD_SEL_2K = 3'h2;
  localparam logic [2:0] PFD_SEL_4K = 3'h3;
  localparam logic [2:0] PFD_SEL_8K = 3'h4;
  localparam logic [2:0] PFD_SEL_16K = 3'h5;
  localparam logic [2:0] PFD_SEL_RESET = PFD_SEL_16K;
  // Status bits
  localparam int PFD_ST_EXT_BIT = 0;
  localparam int PFD_ST_FORCE_BIT = 1;
  localparam int PFD_ST_REJ_BIT = 2;
  localparam int PFD_ST_BAD_BIT = 3;
  // Top of full on-chip ROM
  localparam logic [15:0] PFD_ROM_TOP = 16'h3fff;

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_ROM = 2'b01,
    PFD_EXT = 2'b10
  } pfd_state_t;

  // Number of on-chip bytes for a size code; zero for none or reserved
  function automatic logic [16:0] pfd_limit_bytes(input logic [2:0] sel);
    case (sel)
      PFD_SEL_1K: pfd_limit_bytes = 17'h00400;
      PFD_SEL_2K: pfd_limit_bytes = 17'h00800;
      PFD_SEL_4K: pfd_limit_bytes = 17'h01000;
      PFD_SEL_8K: pfd_limit_bytes = 17'h02000;
      PFD_SEL_16K: pfd_limit_bytes = 17'h04000;
      default: pfd_limit_bytes = 17'h00000;
    endcase
  endfunction : pfd_limit_bytes

  function automatic logic pfd_sel_valid(input logic [2:0] sel);
    pfd_sel_valid = (sel <= PFD_SEL_16K);
  endfunction : pfd_sel_valid
endpackage : pfd_pkg

// ---- logic/pfd_rom.sv ----
`timescale 1ns/1ps
module pfd_rom import pfd_pkg::*; #(
  parameter int AW = 14,
  parameter int DW = 8
) (
  // Clocking
  input wire logic core_clk,
  input wire logic ce,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  // Contents are loaded by the programmer; simulation sees zeros
  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : pfd_rom

// ---- logic/pfd_top.sv ----
`timescale 1ns/1ps
// What this block does
// - On-chip ROM is decoded from address zero up to the 16 KB boundary at full size.
// - Fetches above the selected on-chip limit go out on the external ports.
// - Size codes 0..5 select none, 1, 2, 4, 8 and 16 KB; codes 6 and 7 are reserved.
// - Reset leaves the on-chip limit at 16 KB.
// - The size field changes only through a timed-access permitted write.
// - A new limit applies to the very next fetch.
// - Size zero sends the whole address space to external memory.
// - At full size, with the force-external pin high, no external fetch is made below 16 KB.
// - External fetches put address low/data on the low port and address high on the high port.
// - A low force-external pin sends every fetch outside, whatever the size code.
// - The program-store strobe goes low during every external fetch.
// - The data SRAM is never a fetch source.
module pfd_top import pfd_pkg::*; (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timed-access permit
  input wire logic ta_write_permit,
  // Core fetch side
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic fetch_ack,
  output logic [7:0] fetch_data,
  output logic fetch_ext,
  // External program memory pins
  input wire logic force_external_fetch_n,
  input wire logic [7:0] low_addr_data_port_in,
  output logic [7:0] low_addr_data_port_out,
  output logic low_addr_data_port_oe,
  output logic [7:0] high_addr_port,
  output logic addr_latch_en,
  output logic program_store_strobe_n
);
  logic [2:0] size_sel_r;
  logic reject_r;
  logic bad_code_r;
  logic [31:0] ext_cnt_r;
  logic force_m_r;
  logic force_s_r;
  logic [7:0] port_in_m_r;
  logic [7:0] port_in_s_r;
  pfd_state_t state_r;
  logic [1:0] phase_r;
  logic [15:0] addr_r;
  logic [7:0] rom_q;
  logic go_ext;
  logic apb_acc;
  logic wr_limit;
  logic [16:0] limit;

  // Pins from outside are synchronised before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      force_m_r <= 1'b1;
      force_s_r <= 1'b1;
      port_in_m_r <= 8'h00;
      port_in_s_r <= 8'h00;
    end else if (ce) begin
      force_m_r <= force_external_fetch_n;
      force_s_r <= force_m_r;
      port_in_m_r <= low_addr_data_port_in;
      port_in_s_r <= port_in_m_r;
    end
  end

  // APB answers in the access cycle, no wait states
  assign apb_acc = psel && penable;
  assign pready = 1'b1;
  assign wr_limit = apb_acc && pwrite && (paddr == PFD_ROM_LIMIT_OFF) && ce;

  always_comb begin
    pslverr = 1'b0;
    if (apb_acc && !((paddr == PFD_ROM_LIMIT_OFF) || (paddr == PFD_STATUS_OFF)
        || (paddr == PFD_FETCH_CNT_OFF))) begin
      pslverr = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      case (paddr)
        PFD_ROM_LIMIT_OFF: prdata <= {29'h0, size_sel_r};
        PFD_STATUS_OFF: prdata <= {28'h0, bad_code_r, reject_r, !force_s_r,
                                   state_r == PFD_EXT};
        PFD_FETCH_CNT_OFF: prdata <= ext_cnt_r;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Size register; refused writes are flagged sticky until a good write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      size_sel_r <= PFD_SEL_RESET;
      reject_r <= 1'b0;
      bad_code_r <= 1'b0;
    end else if (wr_limit) begin
      if (!ta_write_permit) begin
        reject_r <= 1'b1;
      end else if (!pfd_sel_valid(pwdata[PFD_SEL_LSB +: PFD_SEL_W])) begin
        bad_code_r <= 1'b1;
      end else begin
        size_sel_r <= pwdata[PFD_SEL_LSB +: PFD_SEL_W];
        reject_r <= 1'b0;
        bad_code_r <= 1'b0;
      end
    end
  end

  // Decode is combinational on the live register so a new limit hits the next fetch
  assign limit = pfd_limit_bytes(size_sel_r);
  // Only the ROM or the external bus can serve a fetch; data SRAM is never in this path
  assign go_ext = !force_s_r || ({1'b0, fetch_addr} >= limit);

  pfd_rom #(.AW(14), .DW(8)) u_rom (
    .core_clk(core_clk),
    .ce(ce),
    .rd_en(fetch_req && state_r == PFD_IDLE && !go_ext),
    .rd_addr(fetch_addr[13:0]),
    .rd_data(rom_q)
  );

  // Fetch sequencer: ROM takes one cycle, external takes address, strobe, sample
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= PFD_IDLE;
      phase_r <= 2'h0;
      addr_r <= 16'h0000;
    end else if (ce) begin
      case (state_r)
        PFD_IDLE: begin
          phase_r <= 2'h0;
          if (fetch_req) begin
            addr_r <= fetch_addr;
            state_r <= go_ext ? PFD_EXT : PFD_ROM;
          end
        end
        PFD_ROM: state_r <= PFD_IDLE;
        PFD_EXT: begin
          phase_r <= phase_r + 2'h1;
          if (phase_r == 2'h3) begin
            state_r <= PFD_IDLE;
          end
        end
        default: state_r <= PFD_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fetch_data <= 8'h00;
      fetch_ack <= 1'b0;
      fetch_ext <= 1'b0;
    end else if (ce) begin
      fetch_ack <= 1'b0;
      if (state_r == PFD_ROM) begin
        fetch_data <= rom_q;
        fetch_ack <= 1'b1;
        fetch_ext <= 1'b0;
      end else if (state_r == PFD_EXT && phase_r == 2'h3) begin
        fetch_data <= port_in_s_r;
        fetch_ack <= 1'b1;
        fetch_ext <= 1'b1;
      end
    end
  end

  // External bus pins; the request cycle drives address low with latch enable, phase 0 releases it and drops the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_addr_data_port_out <= 8'h00;
      low_addr_data_port_oe <= 1'b0;
      high_addr_port <= 8'hff;
      addr_latch_en <= 1'b0;
      program_store_strobe_n <= 1'b1;
    end else if (ce) begin
      if (state_r == PFD_IDLE && fetch_req && go_ext) begin
        low_addr_data_port_out <= fetch_addr[7:0];
        low_addr_data_port_oe <= 1'b1;
        high_addr_port <= fetch_addr[15:8];
        addr_latch_en <= 1'b1;
      end else if (state_r == PFD_EXT && phase_r == 2'h0) begin
        low_addr_data_port_oe <= 1'b0;
        addr_latch_en <= 1'b0;
        program_store_strobe_n <= 1'b0;
      end else if (state_r == PFD_EXT && phase_r == 2'h3) begin
        program_store_strobe_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_cnt_r <= 32'h0000_0000;
    end else if (ce && state_r == PFD_EXT && phase_r == 2'h3) begin
      ext_cnt_r <= ext_cnt_r + 32'h1;
    end
  end

  // Checks
  sequence ext_start_s;
    ce && state_r == PFD_IDLE && fetch_req && go_ext;
  endsequence

  full_size_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == PFD_EXT && force_s_r && size_sel_r == PFD_SEL_16K && phase_r == 2'h0)
      |-> addr_r > PFD_ROM_TOP)
    else $error("external fetch below 16K at full size");

  strobe_low_a: assert property (@(posedge core_clk) disable iff (rst)
    ext_start_s ##1 ce |=> !program_store_strobe_n)
    else $error("program strobe not low in external fetch");

  no_strobe_rom_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r != PFD_EXT |-> ##1 (program_store_strobe_n || $past(state_r) == PFD_EXT))
    else $error("strobe without external fetch");

  force_ext_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && state_r == PFD_IDLE && fetch_req && !force_s_r) |=> state_r == PFD_EXT)
    else $error("forced fetch not external");

  limit_route_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && state_r == PFD_IDLE && fetch_req && force_s_r)
      |=> (state_r == PFD_EXT) == ({1'b0, addr_r} >= $past(limit)))
    else $error("fetch routed against limit");

  zero_size_a: assert property (@(posedge core_clk) disable iff (rst)
    (ce && state_r == PFD_IDLE && fetch_req && size_sel_r == PFD_SEL_NONE) |=> state_r == PFD_EXT)
    else $error("zero size fetched on chip");

  no_permit_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_limit && !ta_write_permit) |=> $stable(size_sel_r) && reject_r)
    else $error("unpermitted write changed size");

  bad_code_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_limit && pwdata[2:1] == 2'b11) |=> $stable(size_sel_r))
    else $error("reserved code accepted");

  good_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_limit && ta_write_permit && pwdata[2:0] <= 3'h5) |=> size_sel_r == $past(pwdata[2:0]))
    else $error("permitted write not taken");

  ext_ack_a: assert property (@(posedge core_clk) disable iff (rst)
    ext_start_s ##1 ce ##1 ce ##1 ce ##1 ce |=> fetch_ack && fetch_ext)
    else $error("external fetch did not complete");
endmodule : pfd_top

// ---- verification/pfd_ext_mem.sv ----
`timescale 1ns/1ps
module pfd_ext_mem (
  // Bus pins
  input wire logic core_clk,
  input wire logic [7:0] low_addr_data_port_out,
  input wire logic [7:0] high_addr_port,
  input wire logic addr_latch_en,
  input wire logic program_store_strobe_n,
  output logic [7:0] low_addr_data_port_in
);
  logic [15:0] addr_r = 16'h0000;
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge core_clk) begin
    if (addr_latch_en) addr_r <= {high_addr_port, low_addr_data_port_out};
  end
  always_ff @(posedge core_clk) begin
    if (!program_store_strobe_n) last_r <= low_addr_data_port_in;
  end
  // Released bus shows the inverse of the last byte, so stale data cannot pass
  always_comb begin
    if (!program_store_strobe_n) low_addr_data_port_in = addr_r[7:0] ^ addr_r[15:8] ^ 8'h5a;
    else low_addr_data_port_in = ~last_r;
  end
endmodule : pfd_ext_mem

// ---- verification/program_fetch_decoder_bench.sv ----
`timescale 1ns/1ps
module program_fetch_decoder_bench import pfd_pkg::*;;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, port_in, port_out, hi;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, permit = 1'b0, req = 1'b0, ack, ext, oe, ale, strb_n;
  logic [15:0] faddr = 16'h0000;
  logic [7:0] fdata;
  logic force_n = 1'b1;
  logic ce_in = 1'b1;
  int fail_count = 0, comparisons = 0, cycles = 0;
  pfd_top i_dut (.core_clk(core_clk), .rst(rst), .ce(ce_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ta_write_permit(permit), .fetch_req(req), .fetch_addr(faddr),
    .fetch_ack(ack), .fetch_data(fdata), .fetch_ext(ext), .force_external_fetch_n(force_n),
    .low_addr_data_port_in(port_in), .low_addr_data_port_out(port_out),
    .low_addr_data_port_oe(oe), .high_addr_port(hi), .addr_latch_en(ale),
    .program_store_strobe_n(strb_n));
  pfd_ext_mem i_mem (.core_clk(core_clk), .low_addr_data_port_out(port_out),
    .high_addr_port(hi), .addr_latch_en(ale), .program_store_strobe_n(strb_n),
    .low_addr_data_port_in(port_in));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic p);
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; permit <= p;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0; permit <= 1'b0;
  endtask : apb
  task automatic fetch(input logic [15:0] a, input logic exp_ext);
    logic seen_strb;
    seen_strb = 1'b0;
    @(posedge core_clk);
    req <= 1'b1; faddr <= a;
    // Taken at the next edge, since the sequencer is idle between calls
    @(posedge core_clk);
    req <= 1'b0;
    repeat (20) begin
      @(negedge core_clk);
      if (strb_n === 1'b0) seen_strb = 1'b1;
      if (ack === 1'b1) break;
    end
    check("fetch_ack", ack, 1'b1);
    check("fetch_ext", ext, exp_ext);
    check("strobe_low", seen_strb, exp_ext);
    if (exp_ext) check("ext_data", fdata, a[7:0] ^ a[15:8] ^ 8'h5a);
  endtask : fetch
  task automatic t_reset();
    apb(1'b0, PFD_ROM_LIMIT_OFF, 32'h0, 1'b0);
    check("limit_reset", q, 32'h5);
    fetch(16'h3fff, 1'b0);
    fetch(16'h0000, 1'b0);
    fetch(16'h4000, 1'b1);
  endtask : t_reset
  task automatic t_freeze();
    @(posedge core_clk);
    ce_in <= 1'b0;
    apb(1'b1, PFD_ROM_LIMIT_OFF, 32'h1, 1'b1);
    ce_in <= 1'b1;
    apb(1'b0, PFD_ROM_LIMIT_OFF, 32'h0, 1'b0);
    check("limit_frozen", q, 32'h5);
  endtask : t_freeze
  task automatic t_sizes();
    logic [16:0] lim;
    for (int i = 0; i < 6; i++) begin
      lim = (i == 0) ? 17'h0 : (17'h1 << (9 + i));
      // The bench issues no fetch while the limit changes
      apb(1'b1, PFD_ROM_LIMIT_OFF, i, 1'b1);
      if (i == 0) begin
        fetch(16'h0000, 1'b1);
        fetch(16'hffff, 1'b1);
      end else begin
        fetch(lim[15:0], 1'b1);
        fetch(lim[15:0] - 16'h1, 1'b0);
      end
    end
  endtask : t_sizes
  task automatic t_refuse();
    apb(1'b1, PFD_ROM_LIMIT_OFF, 32'h1, 1'b0);
    apb(1'b0, PFD_ROM_LIMIT_OFF, 32'h0, 1'b0);
    check("limit_no_permit", q, 32'h5);
    apb(1'b0, PFD_STATUS_OFF, 32'h0, 1'b0);
    check("refused_flag", q[PFD_ST_REJ_BIT], 1'b1);
    apb(1'b1, PFD_ROM_LIMIT_OFF, 32'h6, 1'b1);
    apb(1'b0, PFD_STATUS_OFF, 32'h0, 1'b0);
    check("bad_code_flag", q[PFD_ST_BAD_BIT], 1'b1);
    fetch(16'h3fff, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 1'b0);
    check("unmapped_err", err, 1'b1);
    check("unmapped_data", q, 32'h0);
  endtask : t_refuse
  task automatic t_force();
    @(posedge core_clk);
    force_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    fetch(16'h0010, 1'b1);
    apb(1'b0, PFD_STATUS_OFF, 32'h0, 1'b0);
    check("force_flag", q[PFD_ST_FORCE_BIT], 1'b1);
    force_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    fetch(16'h0010, 1'b0);
  endtask : t_force
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_sizes();
    t_refuse();
    t_freeze();
    t_force();
    finish_test();
  end
endmodule : program_fetch_decoder_bench
